// ==== hw/pea_pkg.sv ====
// Summary of operation
// - Each phase holds a 32-bit raw current level, refreshed every DSP cycle.
// - Each DSP cycle a positive real power sample adds into the positive accumulator.
// - A positive accumulator wrap sets that phase's positive wrap flag.
// - Each DSP cycle a negative real sample's magnitude adds into the negative accumulator.
// - A negative accumulator wrap sets that phase's negative wrap flag.
// - Each DSP cycle the kVA sample adds, unconditionally, into the kVA accumulator.
// - A kVA accumulator wrap sets that phase's kVA wrap flag.
// - Scaled voltage equals raw voltage level times the voltage scale coefficient.
// - Scaled current of A, B, C and neutral equals raw current times current coefficient.
// - Wrap status byte: kVA flag bit 4, negative bit 1, positive bit 0, rest zero.
// - A wrap flag stays set until the host clears it or reset clears it; a DSP cycle never clears it.
package pea_pkg;
  localparam int DATA_W   = 32;
  localparam int COEF_W   = 16;
  localparam int PROD_W   = DATA_W + COEF_W;
  localparam int RD_W     = 64;
  localparam int ADDR_W   = 12;
  localparam int NPH      = 3;
  localparam int STATUS_W = 8;

  localparam logic [ADDR_W-1:0] ADR_VOLT_COEFF = 12'h014;
  localparam logic [ADDR_W-1:0] ADR_CURR_COEFF = 12'h016;
  localparam logic [ADDR_W-1:0] ADR_SCALED_I_N = 12'h840;
  // Per-phase maps, index 0 is phase A.
  localparam logic [NPH-1:0][ADDR_W-1:0] ADR_RAW_I    = {12'h3A4, 12'h2B8, 12'h1CC};
  localparam logic [NPH-1:0][ADDR_W-1:0] ADR_POS      = {12'h3C0, 12'h2D4, 12'h1E8};
  localparam logic [NPH-1:0][ADDR_W-1:0] ADR_NEG      = {12'h3C4, 12'h2D8, 12'h1EC};
  localparam logic [NPH-1:0][ADDR_W-1:0] ADR_KVA      = {12'h3D0, 12'h2E4, 12'h1F8};
  localparam logic [NPH-1:0][ADDR_W-1:0] ADR_WRAP     = {12'h31E, 12'h232, 12'h146};
  localparam logic [NPH-1:0][ADDR_W-1:0] ADR_SCALED_V = {12'h834, 12'h832, 12'h831};
  localparam logic [NPH-1:0][ADDR_W-1:0] ADR_SCALED_I = {12'h844, 12'h842, 12'h841};

  localparam int WRAP_POS_BIT = 0;
  localparam int WRAP_NEG_BIT = 1;
  localparam int WRAP_KVA_BIT = 4;

  localparam logic [COEF_W-1:0] COEFF_RST = 16'h0001;
  localparam logic [DATA_W-1:0] LEVEL_RST = 32'h00000000;
  localparam logic [DATA_W-1:0] ACC_RST   = 32'h00000000;

  typedef struct packed {
    logic [DATA_W-1:0]        raw_voltage_level;
    logic [DATA_W-1:0]        raw_current_level;
    logic signed [DATA_W-1:0] phase_real_power_sample;
    logic [DATA_W-1:0]        phase_kva_sample;
  } pea_phase_in_type;

  typedef struct packed {
    logic [DATA_W-1:0] pos_real_energy_acc;
    logic [DATA_W-1:0] neg_real_energy_acc;
    logic [DATA_W-1:0] kva_energy_acc;
    logic              pos_acc_wrap_flag;
    logic              neg_acc_wrap_flag;
    logic              kva_acc_wrap_flag;
  } pea_acc_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
  } pea_reg_req_type;

  typedef struct packed {
    logic            valid;
    logic [RD_W-1:0] data;
  } pea_reg_rsp_type;

  typedef struct packed {
    logic [COEF_W-1:0]          voltage_scale_coeff;
    logic [COEF_W-1:0]          current_scale_coeff;
    logic [NPH-1:0][DATA_W-1:0] raw_current_level;
    logic [NPH-1:0][DATA_W-1:0] raw_voltage_level;
    logic [DATA_W-1:0]          neutral_current_level;
    pea_reg_rsp_type            rsp;
  } pea_top_state_type;
endpackage

// ==== hw/pea_phase_acc.sv ====
`timescale 1ns/1ps
module pea_phase_acc (
  // Clock and reset
  input  wire logic                             mclk,
  input  wire logic                             rst,
  // DSP cycle samples
  input  wire logic                             dsp_tick,
  input  wire logic signed [pea_pkg::DATA_W-1:0] real_sample,
  input  wire logic [pea_pkg::DATA_W-1:0]       kva_sample,
  // Host clears, bit 0 positive, bit 1 negative, bit 2 kVA
  input  wire logic [2:0]                       wrap_clr,
  // Accumulator state
  output pea_pkg::pea_acc_type                  acc
);
  localparam int W = pea_pkg::DATA_W;

  pea_pkg::pea_acc_type s_q;
  pea_pkg::pea_acc_type s_d;
  logic [W:0]           pos_sum;
  logic [W:0]           neg_sum;
  logic [W:0]           kva_sum;
  logic [W-1:0]         neg_mag;

  always_comb begin
    s_d     = s_q;
    neg_mag = W'(-real_sample);
    pos_sum = {1'b0, s_q.pos_real_energy_acc} + {1'b0, real_sample};
    neg_sum = {1'b0, s_q.neg_real_energy_acc} + {1'b0, neg_mag};
    kva_sum = {1'b0, s_q.kva_energy_acc} + {1'b0, kva_sample};
    // Clears are applied first so a wrap in the same cycle still sets the flag.
    if (wrap_clr[0]) begin
      s_d.pos_acc_wrap_flag = 1'b0;
    end
    if (wrap_clr[1]) begin
      s_d.neg_acc_wrap_flag = 1'b0;
    end
    if (wrap_clr[2]) begin
      s_d.kva_acc_wrap_flag = 1'b0;
    end
    if (dsp_tick) begin
      if (!real_sample[W-1]) begin
        s_d.pos_real_energy_acc = pos_sum[W-1:0];
        if (pos_sum[W]) begin
          s_d.pos_acc_wrap_flag = 1'b1;
        end
      end else begin
        s_d.neg_real_energy_acc = neg_sum[W-1:0];
        if (neg_sum[W]) begin
          s_d.neg_acc_wrap_flag = 1'b1;
        end
      end
      s_d.kva_energy_acc = kva_sum[W-1:0];
      if (kva_sum[W]) begin
        s_d.kva_acc_wrap_flag = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign acc = s_q;
endmodule

// ==== hw/pea_phase_energy_accumulators.sv ====
`timescale 1ns/1ps
module pea_phase_energy_accumulators #(
  parameter int NUM_PHASES = pea_pkg::NPH
) (
  // Clock and reset
  input  wire logic                                  mclk,
  input  wire logic                                  rst,
  // DSP cycle results
  input  wire logic                                  dsp_tick,
  input  pea_pkg::pea_phase_in_type [NUM_PHASES-1:0] phase_in,
  input  wire logic [pea_pkg::DATA_W-1:0]            neutral_raw_current_level,
  // Host register port
  input  pea_pkg::pea_reg_req_type                   reg_req,
  output pea_pkg::pea_reg_rsp_type                   reg_rsp
);
  if (NUM_PHASES != pea_pkg::NPH) begin : g_chk
    $error("NUM_PHASES must equal the three metered phases.");
  end

  localparam int W  = pea_pkg::DATA_W;
  localparam int CW = pea_pkg::COEF_W;

  pea_pkg::pea_top_state_type                s_q;
  pea_pkg::pea_top_state_type                s_d;
  pea_pkg::pea_acc_type [NUM_PHASES-1:0]     acc;
  logic [NUM_PHASES-1:0][2:0]                wrap_clr;

  // Unit scaling of a raw level, zero-extended to the response width.
  function automatic logic [pea_pkg::RD_W-1:0] scale(input logic [W-1:0] raw, input logic [CW-1:0] coeff);
    logic [pea_pkg::PROD_W-1:0] prod;
    prod  = raw * coeff;
    scale = {{(pea_pkg::RD_W - pea_pkg::PROD_W){1'b0}}, prod};
  endfunction

  // Wrap status byte of one phase.
  function automatic logic [pea_pkg::STATUS_W-1:0] wrap_byte(input pea_pkg::pea_acc_type a);
    logic [pea_pkg::STATUS_W-1:0] b;
    b = '0;
    b[pea_pkg::WRAP_POS_BIT] = a.pos_acc_wrap_flag;
    b[pea_pkg::WRAP_NEG_BIT] = a.neg_acc_wrap_flag;
    b[pea_pkg::WRAP_KVA_BIT] = a.kva_acc_wrap_flag;
    wrap_byte = b;
  endfunction

  for (genvar ph = 0; ph < NUM_PHASES; ph++) begin : g_phase
    // Writing a one to a status bit clears that flag.
    assign wrap_clr[ph] = (reg_req.wr && reg_req.addr == pea_pkg::ADR_WRAP[ph]) ?
                          {reg_req.wdata[pea_pkg::WRAP_KVA_BIT], reg_req.wdata[pea_pkg::WRAP_NEG_BIT],
                           reg_req.wdata[pea_pkg::WRAP_POS_BIT]} : 3'h0;

    pea_phase_acc u_acc (
      .mclk        (mclk),
      .rst         (rst),
      .dsp_tick    (dsp_tick),
      .real_sample (phase_in[ph].phase_real_power_sample),
      .kva_sample  (phase_in[ph].phase_kva_sample),
      .wrap_clr    (wrap_clr[ph]),
      .acc         (acc[ph])
    );
  end

  always_comb begin
    s_d           = s_q;
    s_d.rsp.valid = 1'b0;
    if (dsp_tick) begin
      for (int ph = 0; ph < NUM_PHASES; ph++) begin
        s_d.raw_current_level[ph] = phase_in[ph].raw_current_level;
        s_d.raw_voltage_level[ph] = phase_in[ph].raw_voltage_level;
      end
      s_d.neutral_current_level = neutral_raw_current_level;
    end
    if (reg_req.wr) begin
      if (reg_req.addr == pea_pkg::ADR_VOLT_COEFF) begin
        s_d.voltage_scale_coeff = reg_req.wdata[CW-1:0];
      end
      if (reg_req.addr == pea_pkg::ADR_CURR_COEFF) begin
        s_d.current_scale_coeff = reg_req.wdata[CW-1:0];
      end
    end
    if (reg_req.rd) begin
      s_d.rsp.valid = 1'b1;
      s_d.rsp.data  = '0;
      if (reg_req.addr == pea_pkg::ADR_VOLT_COEFF) begin
        s_d.rsp.data[CW-1:0] = s_q.voltage_scale_coeff;
      end
      if (reg_req.addr == pea_pkg::ADR_CURR_COEFF) begin
        s_d.rsp.data[CW-1:0] = s_q.current_scale_coeff;
      end
      if (reg_req.addr == pea_pkg::ADR_SCALED_I_N) begin
        s_d.rsp.data = scale(s_q.neutral_current_level, s_q.current_scale_coeff);
      end
      for (int ph = 0; ph < NUM_PHASES; ph++) begin
        if (reg_req.addr == pea_pkg::ADR_RAW_I[ph]) begin
          s_d.rsp.data[W-1:0] = s_q.raw_current_level[ph];
        end
        if (reg_req.addr == pea_pkg::ADR_POS[ph]) begin
          s_d.rsp.data[W-1:0] = acc[ph].pos_real_energy_acc;
        end
        if (reg_req.addr == pea_pkg::ADR_NEG[ph]) begin
          s_d.rsp.data[W-1:0] = acc[ph].neg_real_energy_acc;
        end
        if (reg_req.addr == pea_pkg::ADR_KVA[ph]) begin
          s_d.rsp.data[W-1:0] = acc[ph].kva_energy_acc;
        end
        if (reg_req.addr == pea_pkg::ADR_WRAP[ph]) begin
          s_d.rsp.data[pea_pkg::STATUS_W-1:0] = wrap_byte(acc[ph]);
        end
        if (reg_req.addr == pea_pkg::ADR_SCALED_V[ph]) begin
          s_d.rsp.data = scale(s_q.raw_voltage_level[ph], s_q.voltage_scale_coeff);
        end
        if (reg_req.addr == pea_pkg::ADR_SCALED_I[ph]) begin
          s_d.rsp.data = scale(s_q.raw_current_level[ph], s_q.current_scale_coeff);
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_q                     <= '0;
      s_q.voltage_scale_coeff <= pea_pkg::COEFF_RST;
      s_q.current_scale_coeff <= pea_pkg::COEFF_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rsp = s_q.rsp;
endmodule

// ==== test/pea_props.sv ====
`timescale 1ns/1ps
module pea_props #(
  parameter int NUM_PHASES = 3
) (
  // Clock and reset
  input wire logic                                  mclk,
  input wire logic                                  rst,
  // Observed ports
  input wire logic                                  dsp_tick,
  input pea_pkg::pea_phase_in_type [NUM_PHASES-1:0] phase_in,
  input wire logic [31:0]                           neutral_raw_current_level,
  input pea_pkg::pea_reg_req_type                   reg_req,
  input pea_pkg::pea_reg_rsp_type                   reg_rsp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic pa;
  logic nb;
  logic kc;
  logic wa;
  logic cv;
  logic sv;
  assign pa = reg_req.rd && !reg_req.wr && reg_req.addr == pea_pkg::ADR_POS[0];
  assign nb = reg_req.rd && !reg_req.wr && reg_req.addr == pea_pkg::ADR_NEG[1];
  assign kc = reg_req.rd && !reg_req.wr && reg_req.addr == pea_pkg::ADR_KVA[2];
  assign wa = reg_req.rd && !reg_req.wr && reg_req.addr == pea_pkg::ADR_WRAP[0];
  assign cv = reg_req.rd && !reg_req.wr && reg_req.addr == pea_pkg::ADR_VOLT_COEFF;
  assign sv = reg_req.rd && !reg_req.wr && reg_req.addr == pea_pkg::ADR_SCALED_V[0];
  sequence s_pos;
    dsp_tick && pa && !phase_in[0].phase_real_power_sample[31] ##1 pa && !dsp_tick;
  endsequence
  sequence s_flag;
    dsp_tick && pa && !phase_in[0].phase_real_power_sample[31] ##1 wa && !dsp_tick;
  endsequence
  sequence s_scale;
    dsp_tick ##1 cv && !dsp_tick ##1 sv && !dsp_tick;
  endsequence
  property p_valid;
    reg_rsp.valid == $past(reg_req.rd);
  endproperty
  a_valid: assert property (p_valid) else $error("read answer timing wrong");
  property p_pos;
    s_pos |=> reg_rsp.data == {32'h0, $past(reg_rsp.data[31:0]) + $past(phase_in[0].phase_real_power_sample, 2)};
  endproperty
  a_pos: assert property (p_pos) else $error("positive sum wrong");
  property p_flag;
    s_flag |=> (({1'b0, $past(reg_rsp.data[31:0])} + {1'b0, $past(phase_in[0].phase_real_power_sample, 2)})
      > 33'h0FFFFFFFF) |-> reg_rsp.data[0];
  endproperty
  a_flag: assert property (p_flag) else $error("positive wrap flag missing");
  property p_neg;
    dsp_tick && nb && phase_in[1].phase_real_power_sample[31] ##1 nb && !dsp_tick
      |=> reg_rsp.data == {32'h0, $past(reg_rsp.data[31:0]) - $past(phase_in[1].phase_real_power_sample, 2)};
  endproperty
  a_neg: assert property (p_neg) else $error("negative sum wrong");
  property p_kva;
    dsp_tick && kc ##1 kc && !dsp_tick
      |=> reg_rsp.data == {32'h0, $past(reg_rsp.data[31:0]) + $past(phase_in[2].phase_kva_sample, 2)};
  endproperty
  a_kva: assert property (p_kva) else $error("kVA sum wrong");
  property p_rsvd;
    wa |=> (reg_rsp.data & ~64'h13) == 64'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved status bit set");
  property p_sticky;
    wa ##1 wa |=> (reg_rsp.data[7:0] & $past(reg_rsp.data[7:0])) == $past(reg_rsp.data[7:0]);
  endproperty
  a_sticky: assert property (p_sticky) else $error("wrap flag dropped");
  property p_scale;
    s_scale |=> reg_rsp.data == {48'h0, $past(reg_rsp.data[15:0])} * {32'h0, $past(phase_in[0].raw_voltage_level, 3)};
  endproperty
  a_scale: assert property (p_scale) else $error("scaled voltage wrong");
endmodule

bind pea_phase_energy_accumulators pea_props #(.NUM_PHASES(NUM_PHASES)) props_u (.mclk(mclk), .rst(rst),
  .dsp_tick(dsp_tick), .phase_in(phase_in), .neutral_raw_current_level(neutral_raw_current_level),
  .reg_req(reg_req), .reg_rsp(reg_rsp));

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic                            mclk;
  logic                            rst;
  logic                            dsp_tick;
  pea_pkg::pea_phase_in_type [2:0] phase_in;
  logic [31:0]                     neutral;
  pea_pkg::pea_reg_req_type        reg_req;
  pea_pkg::pea_reg_rsp_type        reg_rsp;
  int                              err_count;
  int                              samples_checked;
  logic [31:0]                     e_pos [3] = '{32'h7FFFFFFB, 32'h0, 32'h0};
  logic [31:0]                     e_neg [3] = '{32'h0, 32'h23, 32'h80000000};
  logic [31:0]                     e_kva [3] = '{32'h5, 32'hF, 32'hFFFFFFFB};
  logic [7:0]                      e_st [3] = '{8'h01, 8'h00, 8'h12};
  localparam logic [63:0] KV = 64'h3E9;
  localparam logic [63:0] KI = 64'h4D2;

  pea_phase_energy_accumulators #(.NUM_PHASES(3)) dut_u (.mclk(mclk), .rst(rst), .dsp_tick(dsp_tick),
    .phase_in(phase_in), .neutral_raw_current_level(neutral), .reg_req(reg_req), .reg_rsp(reg_rsp));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input logic t, input logic r, input logic w, input logic [11:0] a, input logic [31:0] d);
    @(negedge mclk);
    dsp_tick = t;
    reg_req = '{a, r, w, d};
  endtask

  task automatic rd(input logic [11:0] a, input logic [63:0] exp);
    int n;
    cyc(1'b0, 1'b1, 1'b0, a, 32'h0);
    cyc(1'b0, 1'b0, 1'b0, a, 32'h0);
    n = 0;
    while (reg_rsp.valid !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    if (n == 4) begin
      err_count++;
      summarize();
    end else begin
      chk($sformatf("read %h", a), reg_rsp.data, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    cyc(1'b0, 1'b0, 1'b1, a, d);
    cyc(1'b0, 1'b0, 1'b0, a, 32'h0);
  endtask

  // A DSP cycle with a read at its edge and two reads straight after it.
  task automatic tick(input logic [11:0] a1, input logic [11:0] a2, input logic [11:0] a3);
    cyc(1'b1, 1'b1, 1'b0, a1, 32'h0);
    cyc(1'b0, 1'b1, 1'b0, a2, 32'h0);
    cyc(1'b0, 1'b1, 1'b0, a3, 32'h0);
    cyc(1'b0, 1'b0, 1'b0, a3, 32'h0);
  endtask

  initial begin
    err_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    dsp_tick = 1'b0;
    reg_req = '0;
    neutral = 32'h00000222;
    phase_in[0] = '{32'h00123456, 32'h00ABCDEF, 32'h7FFFFFFF, 32'h00000001};
    phase_in[1] = '{32'h00000100, 32'h00000200, 32'hFFFFFFF9, 32'h00000003};
    phase_in[2] = '{32'h00000300, 32'h00000400, 32'h80000000, 32'hFFFFFFFF};
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    rd(pea_pkg::ADR_VOLT_COEFF, 64'h1);
    rd(pea_pkg::ADR_CURR_COEFF, 64'h1);
    rd(pea_pkg::ADR_WRAP[2], 64'h0);
    rd(12'h7FF, 64'h0);
    $display("test reset done");
    wr(pea_pkg::ADR_VOLT_COEFF, 32'h000003E9);
    wr(pea_pkg::ADR_CURR_COEFF, 32'h000004D2);
    rd(pea_pkg::ADR_VOLT_COEFF, KV);
    rd(pea_pkg::ADR_CURR_COEFF, KI);
    $display("test coefficients done");
    tick(pea_pkg::ADR_POS[0], pea_pkg::ADR_POS[0], pea_pkg::ADR_VOLT_COEFF);
    tick(pea_pkg::ADR_NEG[1], pea_pkg::ADR_NEG[1], pea_pkg::ADR_VOLT_COEFF);
    tick(pea_pkg::ADR_POS[0], pea_pkg::ADR_WRAP[0], pea_pkg::ADR_WRAP[0]);
    tick(pea_pkg::ADR_KVA[2], pea_pkg::ADR_KVA[2], pea_pkg::ADR_VOLT_COEFF);
    tick(12'h7FF, pea_pkg::ADR_VOLT_COEFF, pea_pkg::ADR_SCALED_V[0]);
    wr(pea_pkg::ADR_POS[0], 32'h0);
    wr(12'h7FF, 32'h0);
    for (int p = 0; p < 3; p++) begin
      rd(pea_pkg::ADR_RAW_I[p], {32'h0, phase_in[p].raw_current_level});
      rd(pea_pkg::ADR_POS[p], {32'h0, e_pos[p]});
      rd(pea_pkg::ADR_NEG[p], {32'h0, e_neg[p]});
      rd(pea_pkg::ADR_KVA[p], {32'h0, e_kva[p]});
      rd(pea_pkg::ADR_WRAP[p], {56'h0, e_st[p]});
      rd(pea_pkg::ADR_SCALED_V[p], {32'h0, phase_in[p].raw_voltage_level} * KV);
      rd(pea_pkg::ADR_SCALED_I[p], {32'h0, phase_in[p].raw_current_level} * KI);
    end
    rd(pea_pkg::ADR_SCALED_I_N, {32'h0, neutral} * KI);
    $display("test accumulators done");
    wr(pea_pkg::ADR_WRAP[2], 32'h00000002);
    rd(pea_pkg::ADR_WRAP[2], 64'h10);
    $display("test flag clear done");
    summarize();
  end
endmodule
